// ===== design/hsic_ctrl.sv
// host serial irq control: apb registers, channel-4 smi, slot drive, serial port route
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "hsic_map.svh"
module hsic_ctrl
  import hsic_pkg::*;
#(
  parameter int ADDR_SPAN_BITS = 3 // low host address bits ignored in port decode
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lpc_hw_reset,
  input wire logic lpc_sw_reset,
  input wire logic output_buffer_full_ch4,
  input wire logic direct_request_mode_ch4,
  input wire logic fifo_serial_port_enable,
  input wire logic fifo_serial_port_irq,
  input wire logic host_io_valid,
  input wire logic [15:0] host_io_addr,
  output logic fifo_serial_addr_hit,
  output logic [7:0] slot_drive_out,
  output logic [7:0] slot_drive_oe,
  output logic [15:0] host_irq_slot_n,
  output logic host_smi_req,
  output logic irq
);

  // elaboration check on the decode span
  if (ADDR_SPAN_BITS < 0 || ADDR_SPAN_BITS > 8)
  begin : g_bad_span
    $error("ADDR_SPAN_BITS must lie in 0..8");
  end

  // true when the apb address hits a register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // true when the offset is one of ours
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `HSIC_OFF_CTRL4) || hit(a, `HSIC_OFF_LINE_DRIVE) ||
             hit(a, `HSIC_OFF_SP_ROUTE) || hit(a, `HSIC_OFF_SP_ADDR) ||
             hit(a, `HSIC_OFF_IRQ_STATUS) || hit(a, `HSIC_OFF_IRQ_MASK) ||
             hit(a, `HSIC_OFF_STATE);
  endfunction

  // register state
  logic [7:0] ctrl4_r; // bit1 smi enable, bit0 reserved
  logic [7:0] ctrl4_nxt;
  logic smie_armed_r; // a zero was read from the enable
  logic smie_armed_nxt;
  logic [7:0] line_drive_r; // slot drive select
  logic [7:0] line_drive_nxt;
  logic [7:0] sp_route_r; // serial port route, high nibble reserved
  logic [7:0] sp_route_nxt;
  logic [15:0] sp_addr_r; // serial port host address
  logic [15:0] sp_addr_nxt;
  logic [`HSIC_EV_WIDTH-1:0] ev_status_r; // sticky events
  logic [`HSIC_EV_WIDTH-1:0] ev_status_nxt;
  logic [`HSIC_EV_WIDTH-1:0] ev_mask_r; // event mask
  logic [`HSIC_EV_WIDTH-1:0] ev_mask_nxt;
  logic [31:0] prdata_r; // read data captured in setup
  logic [31:0] prdata_nxt;
  logic obf_prev_r; // buffer-full of last cycle
  logic ch4_smi_r; // registered channel-4 smi
  logic ch4_smi_nxt;
  logic sp_smi_r; // registered serial smi
  logic [15:0] sp_slots_r; // registered serial slot requests
  logic sp_req_prev_r; // any serial request last cycle
  logic addr_hit_r; // registered host decode
  logic addr_hit_nxt;

  // apb phase strobes
  logic setup_ph; // first cycle of a transfer
  logic access_ph; // completing cycle
  logic wr_en; // write takes effect
  logic rd_done; // read completes
  logic obf_fall; // buffer-full cleared
  logic smie_hw_clr; // hardware clear of the enable
  logic sp_req_any; // serial route asserts something

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en = access_ph && pwrite && mapped(paddr);
  assign rd_done = access_ph && !pwrite && mapped(paddr);
  assign obf_fall = obf_prev_r && !output_buffer_full_ch4;

  // route decoder
  hsic_route_if rif ();
  assign rif.code = sp_route_r[3:0];
  assign rif.irq_in = fifo_serial_port_irq;
  hsic_route_dec u_dec (
    .rif (rif)
  );
  assign sp_req_any = rif.smi_req || (rif.slot_req != 16'h0000);

  // apb answers: zero wait, error on unmapped offsets
  always_comb
  begin
    pready = 1'b1;
    pslverr = access_ph && !mapped(paddr);
  end
  assign prdata = prdata_r;

  // hardware clears of the channel-4 enable
  always_comb
  begin
    smie_hw_clr = lpc_hw_reset || lpc_sw_reset;
    if (!direct_request_mode_ch4 && obf_fall)
    begin
      smie_hw_clr = 1'b1;
    end
  end

  // next values of the control registers
  always_comb
  begin
    ctrl4_nxt = ctrl4_r;
    smie_armed_nxt = smie_armed_r;
    line_drive_nxt = line_drive_r;
    sp_route_nxt = sp_route_r;
    sp_addr_nxt = sp_addr_r;
    ev_mask_nxt = ev_mask_r;
    // a read returning zero arms the enable
    if (rd_done && hit(paddr, `HSIC_OFF_CTRL4))
    begin
      smie_armed_nxt = !ctrl4_r[`HSIC_CTRL4_SMIE_BIT];
    end
    if (wr_en)
    begin
      // only the slave-side bus reaches these registers
      if (hit(paddr, `HSIC_OFF_CTRL4))
      begin
        ctrl4_nxt[0] = pwdata[0]; // reserved bit, stored as written
        if (!pwdata[`HSIC_CTRL4_SMIE_BIT])
        begin
          ctrl4_nxt[`HSIC_CTRL4_SMIE_BIT] = 1'b0;
        end
        else if (smie_armed_r)
        begin
          ctrl4_nxt[`HSIC_CTRL4_SMIE_BIT] = 1'b1;
        end
        smie_armed_nxt = 1'b0; // a write consumes the arming
      end
      if (hit(paddr, `HSIC_OFF_LINE_DRIVE))
      begin
        line_drive_nxt = pwdata[7:0];
      end
      if (hit(paddr, `HSIC_OFF_SP_ROUTE))
      begin
        sp_route_nxt = pwdata[7:0];
      end
      // address held while the port runs
      if (hit(paddr, `HSIC_OFF_SP_ADDR) && !fifo_serial_port_enable)
      begin
        sp_addr_nxt = pwdata[15:0];
      end
      if (hit(paddr, `HSIC_OFF_IRQ_MASK))
      begin
        ev_mask_nxt = pwdata[`HSIC_EV_WIDTH-1:0];
      end
    end
    // hardware clear wins over a software set in the same cycle
    if (smie_hw_clr)
    begin
      ctrl4_nxt[`HSIC_CTRL4_SMIE_BIT] = 1'b0;
    end
  end

  // channel-4 smi request and host decode
  always_comb
  begin
    if (direct_request_mode_ch4)
    begin
      ch4_smi_nxt = ctrl4_r[`HSIC_CTRL4_SMIE_BIT];
    end
    else
    begin
      ch4_smi_nxt = ctrl4_r[`HSIC_CTRL4_SMIE_BIT] && output_buffer_full_ch4;
    end
    // compare the upper address bits against the programmed base
    addr_hit_nxt = host_io_valid && fifo_serial_port_enable &&
                   ((host_io_addr >> ADDR_SPAN_BITS) == (sp_addr_r >> ADDR_SPAN_BITS));
  end

  // sticky events, set wins over a write-one clear
  always_comb
  begin
    ev_status_nxt = ev_status_r;
    if (wr_en && hit(paddr, `HSIC_OFF_IRQ_STATUS))
    begin
      ev_status_nxt = ev_status_r & ~pwdata[`HSIC_EV_WIDTH-1:0];
    end
    if (ch4_smi_nxt && !ch4_smi_r)
    begin
      ev_status_nxt[`HSIC_EV_CH4_SMI_BIT] = 1'b1;
    end
    if (sp_req_any && !sp_req_prev_r)
    begin
      ev_status_nxt[`HSIC_EV_SP_IRQ_BIT] = 1'b1;
    end
    if (smie_hw_clr && ctrl4_r[`HSIC_CTRL4_SMIE_BIT])
    begin
      ev_status_nxt[`HSIC_EV_SMIE_DROP_BIT] = 1'b1;
    end
  end

  // read data, captured in the setup cycle
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (setup_ph && !pwrite)
    begin
      prdata_nxt = 32'h00000000;
      if (hit(paddr, `HSIC_OFF_CTRL4))
      begin
        prdata_nxt[7:0] = ctrl4_r;
      end
      else if (hit(paddr, `HSIC_OFF_LINE_DRIVE))
      begin
        prdata_nxt[7:0] = line_drive_r;
      end
      else if (hit(paddr, `HSIC_OFF_SP_ROUTE))
      begin
        prdata_nxt[7:0] = sp_route_r;
      end
      else if (hit(paddr, `HSIC_OFF_SP_ADDR))
      begin
        prdata_nxt[15:0] = sp_addr_r;
      end
      else if (hit(paddr, `HSIC_OFF_IRQ_STATUS))
      begin
        prdata_nxt[`HSIC_EV_WIDTH-1:0] = ev_status_r;
      end
      else if (hit(paddr, `HSIC_OFF_IRQ_MASK))
      begin
        prdata_nxt[`HSIC_EV_WIDTH-1:0] = ev_mask_r;
      end
      else if (hit(paddr, `HSIC_OFF_STATE))
      begin
        // live state of the block
        prdata_nxt[4:0] = {host_smi_req, fifo_serial_port_enable,
                           direct_request_mode_ch4, output_buffer_full_ch4, smie_armed_r};
      end
      else
      begin
        prdata_nxt = 32'h00000000; // unmapped reads as zero
      end
    end
  end

  // register all state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl4_r <= `HSIC_CTRL4_RESET;
      smie_armed_r <= 1'b0;
      line_drive_r <= `HSIC_LINE_DRIVE_RESET;
      sp_route_r <= `HSIC_SP_ROUTE_RESET;
      sp_addr_r <= `HSIC_SP_ADDR_RESET;
      ev_status_r <= `HSIC_EV_RESET;
      ev_mask_r <= `HSIC_EV_RESET;
      prdata_r <= 32'h00000000;
      obf_prev_r <= 1'b0;
      ch4_smi_r <= 1'b0;
      sp_smi_r <= 1'b0;
      sp_slots_r <= 16'h0000;
      sp_req_prev_r <= 1'b0;
      addr_hit_r <= 1'b0;
    end
    else
    begin
      ctrl4_r <= ctrl4_nxt;
      smie_armed_r <= smie_armed_nxt;
      line_drive_r <= line_drive_nxt;
      sp_route_r <= sp_route_nxt;
      sp_addr_r <= sp_addr_nxt;
      ev_status_r <= ev_status_nxt;
      ev_mask_r <= ev_mask_nxt;
      prdata_r <= prdata_nxt;
      obf_prev_r <= output_buffer_full_ch4;
      ch4_smi_r <= ch4_smi_nxt;
      sp_smi_r <= rif.smi_req;
      sp_slots_r <= rif.slot_req;
      sp_req_prev_r <= sp_req_any;
      addr_hit_r <= addr_hit_nxt;
    end
  end

  // slot pins: low level driven only while selected
  always_comb
  begin
    slot_drive_out = 8'h00;
    slot_drive_oe = line_drive_r;
  end

  // block outputs
  always_comb
  begin
    host_smi_req = ch4_smi_r || sp_smi_r;
    host_irq_slot_n = sp_slots_r;
    fifo_serial_addr_hit = addr_hit_r;
    irq = |(ev_status_r & ev_mask_r);
  end

endmodule // hsic_ctrl

// ===== design/hsic_map.svh
// register offsets, field positions, reset values and route codes for host serial irq control
`ifndef HSIC_MAP_SVH
`define HSIC_MAP_SVH
// byte offsets on the apb
`define HSIC_OFF_CTRL4 12'h000
`define HSIC_OFF_LINE_DRIVE 12'h004
`define HSIC_OFF_SP_ROUTE 12'h008
`define HSIC_OFF_SP_ADDR 12'h00C
`define HSIC_OFF_IRQ_STATUS 12'h010
`define HSIC_OFF_IRQ_MASK 12'h014
`define HSIC_OFF_STATE 12'h018
// field positions
`define HSIC_CTRL4_SMIE_BIT 1
`define HSIC_EV_CH4_SMI_BIT 0
`define HSIC_EV_SP_IRQ_BIT 1
`define HSIC_EV_SMIE_DROP_BIT 2
`define HSIC_EV_WIDTH 3
// reset values
`define HSIC_CTRL4_RESET 8'h00
`define HSIC_LINE_DRIVE_RESET 8'h00
`define HSIC_SP_ROUTE_RESET 8'h00
`define HSIC_SP_ADDR_RESET 16'h0000
`define HSIC_EV_RESET 3'h0
// route codes
`define HSIC_CODE_NONE 4'h0
`define HSIC_CODE_SMI 4'h2
`endif

// ===== design/hsic_pkg.sv
// types shared by the host serial irq control modules
package hsic_pkg;
  typedef logic [3:0] hsic_code_t; // serial port route code
  typedef logic [15:0] hsic_slots_t; // one bit per host irq slot
endpackage

// ===== design/hsic_route_dec.sv
// decoder that routes the serial port interrupt to one host slot or smi
`timescale 1ns/1ps
`include "hsic_map.svh"
module hsic_route_dec
  import hsic_pkg::*;
(
  hsic_route_if.dec rif
);
  // decode the route code
  always_comb
  begin
    rif.slot_req = '0;
    rif.smi_req = 1'b0;
    if (rif.code == `HSIC_CODE_SMI)
    begin
      rif.smi_req = rif.irq_in;
    end
    else if (rif.code != `HSIC_CODE_NONE)
    begin
      rif.slot_req[rif.code] = rif.irq_in;
    end
  end
endmodule // hsic_route_dec

// ===== design/hsic_route_if.sv
// carrier between the control top and the route decoder
`timescale 1ns/1ps
interface hsic_route_if;
  import hsic_pkg::*;
  hsic_code_t code; // route code from register
  logic irq_in; // serial port interrupt level
  hsic_slots_t slot_req; // decoded slot requests
  logic smi_req; // decoded smi request
  modport ctrl (output code, output irq_in, input slot_req, input smi_req);
  modport dec (input code, input irq_in, output slot_req, output smi_req);
endinterface

// ===== sim/host_serial_irq_control_bench.sv
// self-checking bench for the host serial irq control block
`timescale 1ns/1ps
`include "hsic_map.svh"
module host_serial_irq_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, host_io_valid, fifo_serial_addr_hit, host_smi_req, irq;
  logic lpc_hw_reset = 1'b0, lpc_sw_reset = 1'b0, output_buffer_full_ch4 = 1'b0;
  logic direct_request_mode_ch4 = 1'b0, fifo_serial_port_enable = 1'b0;
  logic fifo_serial_port_irq = 1'b0;
  logic [15:0] host_io_addr, host_irq_slot_n;
  logic [7:0] slot_drive_out, slot_drive_oe, slot_level;
  int bad_count = 0;
  int n_compared = 0;
  always #10 pclk = ~pclk;
  hsic_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lpc_hw_reset(lpc_hw_reset), .lpc_sw_reset(lpc_sw_reset),
    .output_buffer_full_ch4(output_buffer_full_ch4),
    .direct_request_mode_ch4(direct_request_mode_ch4),
    .fifo_serial_port_enable(fifo_serial_port_enable),
    .fifo_serial_port_irq(fifo_serial_port_irq), .host_io_valid(host_io_valid),
    .host_io_addr(host_io_addr), .fifo_serial_addr_hit(fifo_serial_addr_hit),
    .slot_drive_out(slot_drive_out), .slot_drive_oe(slot_drive_oe),
    .host_irq_slot_n(host_irq_slot_n), .host_smi_req(host_smi_req), .irq(irq));
  hsic_host_model m_host (.pclk(pclk), .slot_drive_out(slot_drive_out),
    .slot_drive_oe(slot_drive_oe), .slot_level(slot_level),
    .host_io_valid(host_io_valid), .host_io_addr(host_io_addr));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask
  // read zero arms, then write one
  task automatic set_en;
    apb(`HSIC_OFF_CTRL4, 1'b0, 32'h0);
    apb(`HSIC_OFF_CTRL4, 1'b1, 32'h2);
  endtask
  task automatic t_reset;
    rdchk(`HSIC_OFF_CTRL4, 32'h0);
    rdchk(`HSIC_OFF_LINE_DRIVE, 32'h0);
    rdchk(`HSIC_OFF_SP_ROUTE, 32'h0);
    apb(12'h100, 1'b0, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
  endtask
  task automatic t_smie;
    direct_request_mode_ch4 <= 1'b1;
    apb(`HSIC_OFF_CTRL4, 1'b1, 32'h0);
    apb(`HSIC_OFF_CTRL4, 1'b1, 32'h2);
    settle;
    chk(32'(host_smi_req), 32'h0);
    set_en;
    settle;
    chk(32'(host_smi_req), 32'h1);
    rdchk(`HSIC_OFF_CTRL4, 32'h2);
    apb(`HSIC_OFF_CTRL4, 1'b1, 32'h0);
    settle;
    chk(32'(host_smi_req), 32'h0);
  endtask
  task automatic t_obf;
    direct_request_mode_ch4 <= 1'b0;
    set_en;
    settle;
    chk(32'(host_smi_req), 32'h0);
    @(posedge pclk);
    output_buffer_full_ch4 <= 1'b1;
    settle;
    chk(32'(host_smi_req), 32'h1);
    @(posedge pclk);
    output_buffer_full_ch4 <= 1'b0;
    settle;
    rdchk(`HSIC_OFF_CTRL4, 32'h0);
  endtask
  task automatic t_lpc;
    direct_request_mode_ch4 <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      set_en;
      {lpc_hw_reset, lpc_sw_reset} <= i ? 2'b10 : 2'b01;
      @(posedge pclk);
      {lpc_hw_reset, lpc_sw_reset} <= 2'b00;
      settle;
      chk(32'(host_smi_req), 32'h0);
      rdchk(`HSIC_OFF_CTRL4, 32'h0);
    end
    direct_request_mode_ch4 <= 1'b0;
  endtask
  task automatic t_slots;
    apb(`HSIC_OFF_LINE_DRIVE, 1'b1, 32'hA5);
    @(negedge pclk);
    chk(32'(slot_drive_oe), 32'hA5);
    chk(32'(slot_level), 32'h5A);
  endtask
  // every route code, then the status and mask path
  task automatic t_route;
    fifo_serial_port_irq <= 1'b1;
    for (int c = 0; c < 16; c++)
    begin
      apb(`HSIC_OFF_SP_ROUTE, 1'b1, 32'(c));
      settle;
      chk(32'(host_irq_slot_n), (c == 0 || c == 2) ? 32'h0 : 32'h1 << c);
      chk(32'(host_smi_req), 32'(c == 2));
    end
    apb(`HSIC_OFF_IRQ_MASK, 1'b1, 32'h2);
    settle;
    chk(32'(irq), 32'h1);
    apb(`HSIC_OFF_IRQ_MASK, 1'b1, 32'h0);
    settle;
    chk(32'(irq), 32'h0);
    rdchk(`HSIC_OFF_IRQ_STATUS, 32'h7);
    fifo_serial_port_irq <= 1'b0;
    apb(`HSIC_OFF_IRQ_STATUS, 1'b1, 32'h7);
    rdchk(`HSIC_OFF_IRQ_STATUS, 32'h0);
    apb(`HSIC_OFF_IRQ_MASK, 1'b1, 32'h2);
    settle;
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_addr;
    apb(`HSIC_OFF_SP_ADDR, 1'b1, 32'h1230);
    fifo_serial_port_enable <= 1'b1;
    m_host.host_cycle(16'h1234);
    @(negedge pclk);
    chk(32'(fifo_serial_addr_hit), 32'h1);
    m_host.host_cycle(16'h1334);
    @(negedge pclk);
    chk(32'(fifo_serial_addr_hit), 32'h0);
    rdchk(`HSIC_OFF_SP_ADDR, 32'h1230);
    rdchk(`HSIC_OFF_STATE, 32'h9);
  endtask
  task automatic final_report;
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_smie;
    t_obf;
    t_lpc;
    t_slots;
    t_route;
    t_addr;
    final_report;
  end
  // hang guard
  initial
  begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    final_report;
  end
endmodule // host_serial_irq_control_bench

// ===== sim/hsic_ctrl_chk.sv
// assertion checker for the host serial irq control block
`timescale 1ns/1ps
`include "hsic_map.svh"
module hsic_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lpc_hw_reset,
  input wire logic lpc_sw_reset,
  input wire logic output_buffer_full_ch4,
  input wire logic direct_request_mode_ch4,
  input wire logic fifo_serial_port_enable,
  input wire logic fifo_serial_port_irq,
  input wire logic host_io_valid,
  input wire logic fifo_serial_addr_hit,
  input wire logic [7:0] slot_drive_out,
  input wire logic [7:0] slot_drive_oe,
  input wire logic [15:0] host_irq_slot_n,
  input wire logic host_smi_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // lpc reset kills the enable, so smi drops within three edges
  // a write one cycle later could legally set the enable again, so it is excluded
  property p_lpc_clr;
    (lpc_hw_reset || lpc_sw_reset) && !fifo_serial_port_irq
      ##1 !fifo_serial_port_irq && !(psel && penable && pwrite)
      ##1 !fifo_serial_port_irq |=> !host_smi_req;
  endproperty
  a_lpc_clr: assert property (p_lpc_clr) else $error("smi after lpc reset");
  property p_smi;
    host_smi_req |-> $past(direct_request_mode_ch4 || output_buffer_full_ch4 || fifo_serial_port_irq);
  endproperty
  a_smi: assert property (p_smi) else $error("smi without cause");
  property p_drive;
    slot_drive_out == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("slot driven high");
  // select bits move only on a line-drive write
  property p_oe;
    $changed(slot_drive_oe) |-> $past(psel && penable && pwrite && paddr == `HSIC_OFF_LINE_DRIVE);
  endproperty
  a_oe: assert property (p_oe) else $error("slot select moved alone");
  property p_onehot;
    $onehot0(host_irq_slot_n) && !host_irq_slot_n[0] && !host_irq_slot_n[2];
  endproperty
  a_onehot: assert property (p_onehot) else $error("bad slot pattern");
  property p_route;
    (|host_irq_slot_n) |-> $past(fifo_serial_port_irq);
  endproperty
  a_route: assert property (p_route) else $error("slot without request");
  property p_hit;
    fifo_serial_addr_hit |-> $past(host_io_valid && fifo_serial_port_enable);
  endproperty
  a_hit: assert property (p_hit) else $error("hit without host cycle");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not ready");
  c_smi: cover property ($rose(host_smi_req));
  c_slot: cover property (|host_irq_slot_n);
  c_hit: cover property (fifo_serial_addr_hit);
endmodule // hsic_chk

bind hsic_ctrl hsic_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .lpc_hw_reset(lpc_hw_reset), .lpc_sw_reset(lpc_sw_reset),
  .output_buffer_full_ch4(output_buffer_full_ch4),
  .direct_request_mode_ch4(direct_request_mode_ch4),
  .fifo_serial_port_enable(fifo_serial_port_enable),
  .fifo_serial_port_irq(fifo_serial_port_irq), .host_io_valid(host_io_valid),
  .fifo_serial_addr_hit(fifo_serial_addr_hit), .slot_drive_out(slot_drive_out),
  .slot_drive_oe(slot_drive_oe), .host_irq_slot_n(host_irq_slot_n), .host_smi_req(host_smi_req));

// ===== sim/hsic_host_model.sv
// host chipset side: pulled-up slot wires and host io cycles
`timescale 1ns/1ps
module hsic_host_model
(
  input wire logic pclk,
  input wire logic [7:0] slot_drive_out,
  input wire logic [7:0] slot_drive_oe,
  output logic [7:0] slot_level,
  output logic host_io_valid,
  output logic [15:0] host_io_addr
);
  // wire floats high unless the device drives it
  assign slot_level = (slot_drive_oe & slot_drive_out) | ~slot_drive_oe;
  initial host_io_valid = 1'b0;
  initial host_io_addr = 16'h0000;
  // one-cycle host cycle, address scrambled outside it
  task automatic host_cycle(input logic [15:0] a);
    @(posedge pclk);
    host_io_valid <= 1'b1;
    host_io_addr <= a;
    @(posedge pclk);
    host_io_valid <= 1'b0;
    host_io_addr <= ~a;
  endtask
endmodule // hsic_host_model
